// file: acs_pkg.sv
package acs_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned SYS_PERIOD_NS = 100;
    localparam int unsigned OSC_HZ        = 131072;
    localparam int unsigned CONV_UNIT_NS  = 30520;
    localparam int unsigned CONV_UNIT_CYC = CONV_UNIT_NS / SYS_PERIOD_NS;
    localparam int unsigned HALF_SEC_NS   = 500000000;
    localparam int unsigned HALF_SEC_CYC  = HALF_SEC_NS / SYS_PERIOD_NS;

    // ==========================================================
    // Slot control byte layout
    localparam int unsigned NUM_SLOTS    = 8;
    localparam int unsigned EN_BIT       = 7;
    localparam int unsigned RES_HI       = 6;
    localparam int unsigned RES_LO       = 4;
    localparam int unsigned REF_BIT      = 3;
    localparam int unsigned SEL_HI       = 2;
    localparam int unsigned SEL_LO       = 0;
    localparam int unsigned RES_MIN_BITS = 8;
    localparam int unsigned SIGN_BIT     = 15;
    localparam logic [2:0]  RES_MAX_CODE = 3'h7;

    // Input sources
    localparam logic [2:0] SEL_CURRENT = 3'h0;
    localparam logic [2:0] SEL_DIETEMP = 3'h1;
    localparam logic [2:0] SEL_THERM   = 3'h2;
    localparam logic [2:0] SEL_PACK    = 3'h3;
    localparam logic [2:0] SEL_RSVD    = 3'h4;
    localparam logic [2:0] SEL_GPIN    = 3'h5;
    localparam logic [2:0] SEL_OFFSET  = 3'h6;
    localparam logic [2:0] SEL_RSVD2   = 3'h7;

    // Fixed slot roles
    localparam logic [2:0] SLOT_CURRENT = 3'h0;
    localparam logic [2:0] SLOT_DIETEMP = 3'h1;
    localparam logic [2:0] SLOT_GPIN    = 3'h5;
    localparam logic [2:0] SLOT_LAST    = 3'h7;

    // ==========================================================
    // Serial register map (byte addresses)
    localparam logic [7:0] ADDR_GCTRL  = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h09;
    localparam logic [3:0] PAGE_SLOT   = 4'h0;
    localparam logic [3:0] PAGE_RES    = 4'h1;
    localparam logic [3:0] PAGE_ACC    = 4'h2;
    localparam logic [3:0] PAGE_TIM    = 4'h3;
    localparam logic [3:0] PAGE_ID     = 4'h4;
    localparam int unsigned GCTRL_CONV_EN = 0;
    localparam int unsigned GCTRL_ACC_EN  = 1;

    // Accumulator and timer index
    localparam int unsigned ACC_DRAIN = 0;
    localparam int unsigned ACC_FILL  = 1;
    localparam int unsigned ACC_TEMP  = 2;
    localparam int unsigned ACC_GPIN  = 3;

    // Nonvolatile initial image
    localparam logic [63:0]  INIT_SLOTS = 64'h00000000AB0000F0;
    localparam logic [1:0]   INIT_GCTRL = 2'h0;
    localparam logic [127:0] INIT_ID    = 128'h0;  // Arbitrary value
    localparam logic [6:0]   DEV_ADDR   = 7'h0B;   // Arbitrary value

    // Link bit counter
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK  = 4'h8;

    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'b00,
        SEQ_SELECT  = 2'b01,
        SEQ_CONVERT = 2'b10
    } acs_seq_t;

    typedef enum logic [2:0] {
        LNK_IDLE  = 3'b000,
        LNK_ADDR  = 3'b001,
        LNK_CMD   = 3'b010,
        LNK_WDATA = 3'b011,
        LNK_RDATA = 3'b100
    } acs_link_t;

endpackage

// file: acs_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer #(
    parameter int unsigned    CONV_UNIT_CYC = acs_pkg::CONV_UNIT_CYC,
    parameter int unsigned    HALF_SEC_CYC  = acs_pkg::HALF_SEC_CYC,
    parameter logic [6:0]     DEV_ADDR      = acs_pkg::DEV_ADDR,
    parameter logic [63:0]    INIT_SLOTS    = acs_pkg::INIT_SLOTS,
    parameter logic [127:0]   INIT_ID       = acs_pkg::INIT_ID
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         scl_clk,
    input  wire logic         sda_in,
    output logic              sda_out,
    output logic              sda_oe,
    input  wire logic         conv_sign,
    input  wire logic [14:0]  conv_mag,
    output logic              conv_run,
    output logic [2:0]        conv_input_sel,
    output logic              conv_ref_hi,
    output logic              conv_gnd_short,
    output logic [2:0]        conv_res_code,
    output logic              seq_busy
);

    // ==========================================================
    // State types
    typedef struct packed {
        logic                  start_seen;
        acs_pkg::acs_link_t    phase;
        logic [3:0]            bitcnt;
        logic [7:0]            shreg;
        logic                  ack;
        logic [7:0]            ptr;
        logic                  wr_tog;
        logic [7:0]            wr_addr;
        logic [7:0]            wr_data;
        logic                  rd_tog;
        logic [7:0]            rd_addr;
    } acs_link_st_t;

    typedef struct packed {
        logic                  oe;
        logic                  out;
    } acs_drv_t;

    typedef struct packed {
        logic                  wr_s1;
        logic                  wr_s2;
        logic                  wr_seen;
        logic                  rd_s1;
        logic                  rd_s2;
        logic                  rd_seen;
        logic [7:0]            rd_byte;
        logic [7:0][7:0]       slots;
        logic [1:0]            gctrl;
        logic [127:0]          id;
        acs_pkg::acs_seq_t     seq;
        logic [2:0]            slot;
        logic [31:0]           cnt;
        logic [7:0][15:0]      res;
        logic [3:0][31:0]      acc;
        logic [3:0][31:0]      tim;
        logic [31:0]           half_cnt;
        logic                  run;
        logic [2:0]            sel;
        logic                  ref_hi;
        logic                  gnd;
        logic [2:0]            res_code;
        logic                  busy;
    } acs_sys_t;

    acs_link_st_t l_r;
    acs_link_st_t l_nxt;
    acs_drv_t     d_r;
    acs_drv_t     d_nxt;
    acs_sys_t     s_r;
    acs_sys_t     s_nxt;
    logic         start_tog;
    logic [7:0]   byte_v;
    logic         wr_ev;
    logic         rd_ev;
    logic         tick;
    logic [7:0]   cur;
    logic [14:0]  mag_sh;

    // ==========================================================
    // Start condition: falling data while clock high
    always_ff @(negedge sda_in or posedge rst) begin
        if (rst) begin
            start_tog <= 1'b0;
        end else if (scl_clk) begin
            start_tog <= ~start_tog;
        end
    end

    // ==========================================================
    // Link receive and pointer logic
    always_comb begin
        l_nxt            = l_r;
        byte_v           = {l_r.shreg[6:0], sda_in};
        l_nxt.start_seen = start_tog;
        if (start_tog != l_r.start_seen) begin
            l_nxt.phase  = acs_pkg::LNK_ADDR;
            l_nxt.bitcnt = 4'h1;
            l_nxt.shreg  = byte_v;
            l_nxt.ack    = 1'b0;
        end else if (l_r.phase != acs_pkg::LNK_IDLE) begin
            if (l_r.bitcnt == acs_pkg::BIT_ACK) begin
                l_nxt.bitcnt = 4'h0;
                l_nxt.ack    = 1'b0;
                if (l_r.phase == acs_pkg::LNK_RDATA && sda_in) begin
                    l_nxt.phase = acs_pkg::LNK_IDLE;
                end
            end else begin
                l_nxt.shreg  = byte_v;
                l_nxt.bitcnt = l_r.bitcnt + 4'h1;
                if (l_r.bitcnt == acs_pkg::BIT_LAST) begin
                    unique case (l_r.phase)
                        acs_pkg::LNK_ADDR: begin
                            if (byte_v[7:1] == DEV_ADDR) begin
                                l_nxt.ack   = 1'b1;
                                l_nxt.phase = byte_v[0] ? acs_pkg::LNK_RDATA
                                                        : acs_pkg::LNK_CMD;
                            end else begin
                                l_nxt.phase = acs_pkg::LNK_IDLE;
                            end
                        end
                        acs_pkg::LNK_CMD: begin
                            l_nxt.ack     = 1'b1;
                            l_nxt.ptr     = byte_v;
                            l_nxt.rd_addr = byte_v;
                            l_nxt.rd_tog  = ~l_r.rd_tog;
                            l_nxt.phase   = acs_pkg::LNK_WDATA;
                        end
                        acs_pkg::LNK_WDATA: begin
                            l_nxt.ack     = 1'b1;
                            l_nxt.wr_addr = l_r.ptr;
                            l_nxt.wr_data = byte_v;
                            l_nxt.wr_tog  = ~l_r.wr_tog;
                            l_nxt.ptr     = l_r.ptr + 8'h01;
                            l_nxt.rd_addr = l_r.ptr + 8'h01;
                            l_nxt.rd_tog  = ~l_r.rd_tog;
                        end
                        acs_pkg::LNK_RDATA: begin
                            l_nxt.ptr     = l_r.ptr + 8'h01;
                            l_nxt.rd_addr = l_r.ptr + 8'h01;
                            l_nxt.rd_tog  = ~l_r.rd_tog;
                        end
                        default: begin
                            l_nxt.phase = acs_pkg::LNK_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    // ==========================================================
    // Data line drive on falling clock
    always_comb begin
        d_nxt     = d_r;
        d_nxt.out = 1'b0;
        if (l_r.bitcnt == acs_pkg::BIT_ACK) begin
            d_nxt.oe = l_r.ack;
        end else if (l_r.phase == acs_pkg::LNK_RDATA) begin
            d_nxt.oe = ~s_r.rd_byte[~l_r.bitcnt[2:0]];
        end else begin
            d_nxt.oe = 1'b0;
        end
    end

    always_ff @(negedge scl_clk or posedge rst) begin
        if (rst) begin
            d_r <= '0;
        end else begin
            d_r <= d_nxt;
        end
    end

    // ==========================================================
    // Register read view
    function automatic logic [7:0] rd_mux(input logic [7:0] a, input acs_sys_t s);
        logic [7:0] v;
        v = 8'h00;
        unique case (a[7:4])
            acs_pkg::PAGE_SLOT: begin
                if (!a[3]) begin
                    v = s.slots[a[2:0]];
                end else if (a == acs_pkg::ADDR_GCTRL) begin
                    v = {6'h00, s.gctrl};
                end else if (a == acs_pkg::ADDR_STATUS) begin
                    v = {4'h0, s.busy, s.slot};
                end
            end
            acs_pkg::PAGE_RES: v = s.res[a[3:1]][a[0]*8 +: 8];
            acs_pkg::PAGE_ACC: v = s.acc[a[3:2]][a[1:0]*8 +: 8];
            acs_pkg::PAGE_TIM: v = s.tim[a[3:2]][a[1:0]*8 +: 8];
            acs_pkg::PAGE_ID:  v = s.id[a[3:0]*8 +: 8];
            default:           v = 8'h00;
        endcase
        return v;
    endfunction

    // ==========================================================
    // Sequencer, register file and accumulators
    always_comb begin
        s_nxt         = s_r;
        s_nxt.wr_s1   = l_r.wr_tog;
        s_nxt.wr_s2   = s_r.wr_s1;
        s_nxt.wr_seen = s_r.wr_s2;
        s_nxt.rd_s1   = l_r.rd_tog;
        s_nxt.rd_s2   = s_r.rd_s1;
        s_nxt.rd_seen = s_r.rd_s2;
        wr_ev         = s_r.wr_s2 != s_r.wr_seen;
        rd_ev         = s_r.rd_s2 != s_r.rd_seen;
        cur           = s_r.slots[s_r.slot];
        mag_sh        = conv_mag << (acs_pkg::RES_MAX_CODE - s_r.res_code);

        // Host writes and read fetches
        if (wr_ev) begin
            if (l_r.wr_addr[7:3] == 5'h00) begin
                s_nxt.slots[l_r.wr_addr[2:0]] = l_r.wr_data;
            end else if (l_r.wr_addr == acs_pkg::ADDR_GCTRL) begin
                s_nxt.gctrl = l_r.wr_data[1:0];
            end
        end
        if (rd_ev) begin
            s_nxt.rd_byte = rd_mux(l_r.rd_addr, s_r);
        end

        // Conversion slot walk
        unique case (s_r.seq)
            acs_pkg::SEQ_IDLE: begin
                s_nxt.busy = 1'b0;
                s_nxt.slot = 3'h0;
                if (s_r.gctrl[acs_pkg::GCTRL_CONV_EN]) begin
                    s_nxt.seq  = acs_pkg::SEQ_SELECT;
                    s_nxt.busy = 1'b1;
                end
            end
            acs_pkg::SEQ_SELECT: begin
                if (cur[acs_pkg::EN_BIT]) begin
                    s_nxt.seq      = acs_pkg::SEQ_CONVERT;
                    s_nxt.run      = 1'b1;
                    s_nxt.sel      = cur[acs_pkg::SEL_HI:acs_pkg::SEL_LO];
                    s_nxt.ref_hi   = cur[acs_pkg::REF_BIT];
                    s_nxt.gnd      = cur[acs_pkg::SEL_HI:acs_pkg::SEL_LO]
                                     == acs_pkg::SEL_OFFSET;
                    s_nxt.res_code = cur[acs_pkg::RES_HI:acs_pkg::RES_LO];
                    s_nxt.cnt      = (CONV_UNIT_CYC << (32'(cur[acs_pkg::RES_HI:acs_pkg::RES_LO])
                                     + acs_pkg::RES_MIN_BITS + 32'd1)) - 32'd1;
                end else if (s_r.slot == acs_pkg::SLOT_LAST) begin
                    s_nxt.slot = 3'h0;
                    s_nxt.seq  = s_r.gctrl[acs_pkg::GCTRL_CONV_EN] ? acs_pkg::SEQ_SELECT
                                                                    : acs_pkg::SEQ_IDLE;
                end else begin
                    s_nxt.slot = s_r.slot + 3'h1;
                end
            end
            acs_pkg::SEQ_CONVERT: begin
                if (s_r.cnt == 32'd0) begin
                    s_nxt.run            = 1'b0;
                    s_nxt.gnd            = 1'b0;
                    s_nxt.res[s_r.slot]  = {conv_sign, mag_sh};
                    if (s_r.slot == acs_pkg::SLOT_LAST) begin
                        s_nxt.slot = 3'h0;
                        s_nxt.seq  = s_r.gctrl[acs_pkg::GCTRL_CONV_EN]
                                     ? acs_pkg::SEQ_SELECT : acs_pkg::SEQ_IDLE;
                    end else begin
                        s_nxt.slot = s_r.slot + 3'h1;
                        s_nxt.seq  = acs_pkg::SEQ_SELECT;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - 32'd1;
                end
            end
            default: begin
                s_nxt.seq = acs_pkg::SEQ_IDLE;
            end
        endcase

        // Half-second time base
        tick = s_r.half_cnt == HALF_SEC_CYC - 32'd1;
        s_nxt.half_cnt = tick ? 32'd0 : s_r.half_cnt + 32'd1;
        if (tick && s_r.gctrl[acs_pkg::GCTRL_ACC_EN]) begin
            if (s_r.res[acs_pkg::SLOT_CURRENT][acs_pkg::SIGN_BIT]) begin
                s_nxt.acc[acs_pkg::ACC_DRAIN] = s_r.acc[acs_pkg::ACC_DRAIN]
                    + {17'h00000, s_r.res[acs_pkg::SLOT_CURRENT][14:0]};
                s_nxt.tim[acs_pkg::ACC_DRAIN] = s_r.tim[acs_pkg::ACC_DRAIN] + 32'd1;
            end else begin
                s_nxt.acc[acs_pkg::ACC_FILL] = s_r.acc[acs_pkg::ACC_FILL]
                    + {17'h00000, s_r.res[acs_pkg::SLOT_CURRENT][14:0]};
                s_nxt.tim[acs_pkg::ACC_FILL] = s_r.tim[acs_pkg::ACC_FILL] + 32'd1;
            end
            s_nxt.acc[acs_pkg::ACC_TEMP] = s_r.acc[acs_pkg::ACC_TEMP]
                + {17'h00000, s_r.res[acs_pkg::SLOT_DIETEMP][14:0]};
            s_nxt.tim[acs_pkg::ACC_TEMP] = s_r.tim[acs_pkg::ACC_TEMP] + 32'd1;
            s_nxt.acc[acs_pkg::ACC_GPIN] = s_r.acc[acs_pkg::ACC_GPIN]
                + {17'h00000, s_r.res[acs_pkg::SLOT_GPIN][14:0]};
            s_nxt.tim[acs_pkg::ACC_GPIN] = s_r.tim[acs_pkg::ACC_GPIN] + 32'd1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r       <= '0;
            s_r.slots <= INIT_SLOTS;
            s_r.gctrl <= acs_pkg::INIT_GCTRL;
            s_r.id    <= INIT_ID;
            s_r.seq   <= acs_pkg::SEQ_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign sda_out        = d_r.out;
    assign sda_oe         = d_r.oe;
    assign conv_run       = s_r.run;
    assign conv_input_sel = s_r.sel;
    assign conv_ref_hi    = s_r.ref_hi;
    assign conv_gnd_short = s_r.gnd;
    assign conv_res_code  = s_r.res_code;
    assign seq_busy       = s_r.busy;

endmodule
`default_nettype wire

// file: acs_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Sequencer port checker
module acs_chk #(
    parameter int unsigned CONV_UNIT_CYC = acs_pkg::CONV_UNIT_CYC
) (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        scl_clk,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire logic        conv_sign,
    input wire logic [14:0] conv_mag,
    input wire logic        conv_run,
    input wire logic [2:0]  conv_input_sel,
    input wire logic        conv_ref_hi,
    input wire logic        conv_gnd_short,
    input wire logic [2:0]  conv_res_code,
    input wire logic        seq_busy
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic        oe_rise_r;
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) oe_rise_r <= 1'b0;
        else oe_rise_r <= sda_oe;
    end
    always_comb cnt_nxt = conv_run ? cnt_r + 32'h1 : 32'h0;
    always_ff @(posedge sys_clk) cnt_r <= rst ? 32'h0 : cnt_nxt;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_gnd_short_match: assert property (
        conv_gnd_short == (conv_run && conv_input_sel == acs_pkg::SEL_OFFSET))
        else $error("ground short mismatch");
    a_sda_low_only: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_run_while_busy: assert property (conv_run |-> seq_busy)
        else $error("conversion while idle");
    a_run_start_busy: assert property ($rose(conv_run) |-> $past(seq_busy))
        else $error("conversion without select");
    a_setting_hold: assert property (
        conv_run && $past(conv_run) |-> $stable({conv_input_sel, conv_res_code, conv_ref_hi}))
        else $error("settings moved mid conversion");
    a_conv_length: assert property (
        $fell(conv_run) |-> cnt_r == (CONV_UNIT_CYC << (conv_res_code + 9)))
        else $error("conversion length wrong");
    a_back_to_back: assert property (
        $fell(conv_run) |-> ##[1:12] (conv_run || !seq_busy))
        else $error("gap between conversions");
    a_sda_hold_high: assert property (
        @(negedge scl_clk) disable iff (rst) sda_oe == oe_rise_r)
        else $error("data moved while clock high");
endmodule
bind acs_sequencer acs_chk #(.CONV_UNIT_CYC(CONV_UNIT_CYC)) i_chk (
    .sys_clk(sys_clk), .rst(rst), .scl_clk(scl_clk), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .conv_sign(conv_sign), .conv_mag(conv_mag), .conv_run(conv_run),
    .conv_input_sel(conv_input_sel), .conv_ref_hi(conv_ref_hi),
    .conv_gnd_short(conv_gnd_short), .conv_res_code(conv_res_code), .seq_busy(seq_busy));
`default_nettype wire

// file: acs_host.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Serial bus host model
module acs_host (
    output logic     scl_clk,
    output logic     sda_pull,
    input wire logic sda_line
);
    int nak_cnt = 0;
    initial scl_clk = 1'b1;  // Clock stands high between frames
    initial sda_pull = 1'b0;
    task automatic bit_out(input logic b);
        sda_pull = !b;
        #32 scl_clk = 1'b1;
        #32 scl_clk = 1'b0;
    endtask
    task automatic start();
        sda_pull = 1'b0;
        #32 scl_clk = 1'b1;
        #32 sda_pull = 1'b1;
        #32 scl_clk = 1'b0;
    endtask
    task automatic stop();
        sda_pull = 1'b1;
        #32 scl_clk = 1'b1;
        #32 sda_pull = 1'b0;
    endtask
    task automatic put(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) bit_out(b[i]);
        sda_pull = 1'b0;
        #32 scl_clk = 1'b1;
        ack = !sda_line;
        #32 scl_clk = 1'b0;
        #1000;  // Room for the crossing into the system domain
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic k0, k1, k2;
        start();
        put({acs_pkg::DEV_ADDR, 1'b0}, k0);
        put(a, k1);
        put(d, k2);
        stop();
        if (!(k0 && k1 && k2)) nak_cnt++;
    endtask
    task automatic rd(input logic [7:0] a, input int n, output logic [31:0] v);
        logic k0, k1, k2;
        v = 32'h0;
        start();
        put({acs_pkg::DEV_ADDR, 1'b0}, k0);
        put(a, k1);
        start();
        put({acs_pkg::DEV_ADDR, 1'b1}, k2);
        for (int i = 0; i < n; i++) begin
            sda_pull = 1'b0;
            for (int j = 7; j >= 0; j--) begin
                #32 scl_clk = 1'b1;
                v[8 * i + j] = sda_line;
                #32 scl_clk = 1'b0;
            end
            #1000;
            bit_out(i == n - 1);
        end
        stop();
        if (!(k0 && k1 && k2)) nak_cnt++;
    endtask
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
// ============================================================
// Sequencer bench
module tb;
    localparam int unsigned CU = 1;
    localparam int unsigned HS = 50;
    logic            sys_clk = 1'b0;
    logic            rst = 1'b0;
    logic            conv_sign = 1'b0;
    logic [14:0]     conv_mag = 15'h0;
    wire logic       scl_clk, sda_pull, sda_oe, sda_out, conv_run, conv_ref_hi;
    wire logic       conv_gnd_short, seq_busy;
    wire logic [2:0] conv_input_sel, conv_res_code;
    wire logic       sda = !((sda_oe && !sda_out) || sda_pull);  // Pulled-up line
    int              n_mismatch = 0;
    int              n_compared = 0;
    int              seed = 59;
    int              cyc = 0;
    logic [7:0]      ctl [8];
    logic [15:0]     exp_res [8];
    logic [7:0]      exp_v = 8'h0;
    logic [31:0]     v, w, t, u;
    logic            ack;
    always #50 sys_clk = ~sys_clk;
    acs_host i_host (.scl_clk(scl_clk), .sda_pull(sda_pull), .sda_line(sda));
    acs_sequencer #(.CONV_UNIT_CYC(CU), .HALF_SEC_CYC(HS)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .scl_clk(scl_clk), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .conv_sign(conv_sign), .conv_mag(conv_mag), .conv_run(conv_run),
        .conv_input_sel(conv_input_sel), .conv_ref_hi(conv_ref_hi),
        .conv_gnd_short(conv_gnd_short), .conv_res_code(conv_res_code), .seq_busy(seq_busy));
    task end_of_test();
        $display("counts: compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic run_pass(input int skip);
        int n;
        logic [2:0] r;
        logic [14:0] m;
        for (int i = 0; i < 8; i++) begin
            r = 3'({$random(seed)} % 3);
            ctl[i] = (i == 3) ? 8'hAB : {i != skip, r, 1'($random(seed)), 3'(i)};
            i_host.wr(8'(i), ctl[i]);
        end
        fork
            i_host.wr(acs_pkg::ADDR_GCTRL, 8'h01);  // First conversion watched from its start
        join_none
        for (int s = 0; s < 8; s++) begin
            if (ctl[s][7]) begin
                for (n = 0; n < 200 && conv_run !== 1'b1; n++) tick();
                `CHK("input select", ctl[s][2:0], conv_input_sel)
                `CHK("reference", ctl[s][3], conv_ref_hi)
                `CHK("resolution", ctl[s][6:4], conv_res_code)
                `CHK("ground short", ctl[s][2:0] == 3'h6, conv_gnd_short)
                r = ctl[s][6:4];
                m = 15'($random(seed)) & (15'h7FFF >> (7 - r));
                conv_mag = m;
                conv_sign = ctl[s][3] ? 1'b0 : 1'($random(seed));
                exp_res[s] = {conv_sign, m << (7 - r)};
                exp_v[s] = 1'b1;
                if (s == 7)
                    fork
                        i_host.wr(acs_pkg::ADDR_GCTRL, 8'h00);
                    join_none
                for (n = 0; n < 70000 && conv_run === 1'b1; n++) tick();
                `CHK("conversion length", CU << (r + 9), n)
            end
        end
        for (n = 0; n < 100 && seq_busy !== 1'b0; n++) tick();
        `CHK("idle after pass", 1'b0, seq_busy)
        for (int s = 0; s < 8; s++)
            if (exp_v[s]) begin
                i_host.rd(8'h10 + 8'(2 * s), 2, v);
                `CHK("result word", exp_res[s], v[15:0])
            end
        $display("test pass with slot %0d skipped done", skip);
    endtask
    initial begin
        #1 rst = 1'b1;  // Rising edge resets the link flops
        repeat (2) @(posedge sys_clk);
        #1 rst = 1'b0;
        i_host.rd(8'h00, 1, v);
        `CHK("slot0 initial", 32'hF0, v)
        i_host.rd(8'h03, 1, v);
        `CHK("slot3 initial", 32'hAB, v)
        i_host.rd(acs_pkg::ADDR_GCTRL, 1, v);
        `CHK("control initial", 32'h0, v)
        i_host.rd(8'h50, 1, v);
        `CHK("unmapped read", 32'h0, v)
        i_host.rd(acs_pkg::ADDR_STATUS, 1, v);
        `CHK("status idle", 32'h0, v)
        i_host.rd(8'h40, 1, v);
        `CHK("id byte", 32'(acs_pkg::INIT_ID[7:0]), v)
        i_host.start();
        i_host.put(8'h54, ack);
        i_host.stop();
        `CHK("foreign address ack", 1'b0, ack)
        $display("test reset done");
        run_pass(4);
        run_pass(1);
        i_host.wr(acs_pkg::ADDR_GCTRL, 8'h02);
        repeat (4 * HS + 20) @(posedge sys_clk);
        i_host.wr(acs_pkg::ADDR_GCTRL, 8'h00);
        i_host.rd(8'h20, 4, v);
        i_host.rd(8'h24, 4, w);
        i_host.rd(8'h30, 4, t);
        i_host.rd(8'h34, 4, u);
        `CHK("drain sum", t * (exp_res[0][15] ? exp_res[0][14:0] : 15'h0), v)
        `CHK("fill sum", u * (exp_res[0][15] ? 15'h0 : exp_res[0][14:0]), w)
        `CHK("idle timer", 32'h0, exp_res[0][15] ? u : t)
        `CHK("active timer", 1'b1, (t + u) >= 3 && (t + u) <= 6)
        i_host.rd(8'h28, 4, v);
        i_host.rd(8'h2C, 4, w);
        `CHK("temp sum", (t + u) * exp_res[1][14:0], v)
        `CHK("aux input sum", (t + u) * exp_res[5][14:0], w)
        `CHK("host acks", 0, i_host.nak_cnt)
        $display("test accumulate done");
        end_of_test();
    end
endmodule
`default_nettype wire
